// *** include/sew_defines.svh ***
// constants of the serial eeprom write-control block
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SEW_OP_SET_LATCH   8'h06
`define SEW_OP_CLR_LATCH   8'h04
`define SEW_OP_READ_STATE  8'h05
`define SEW_OP_STORE_PROT  8'h01
`define SEW_OP_RW_MASK     8'hF7
`define SEW_OP_READ        8'h03
`define SEW_OP_WRITE       8'h02
`define SEW_OP_A8_POS      3

// ----------------------------------------------------------------
// state byte layout and reset values
// ----------------------------------------------------------------
`define SEW_ST_PROT_HI     3
`define SEW_ST_PROT_LO     2
`define SEW_ST_LATCH       1
`define SEW_ST_BUSY        0
`define SEW_PROT_RESET     2'h0

// ----------------------------------------------------------------
// protected range starts and timing
// ----------------------------------------------------------------
`define SEW_PROT1_BASE     9'h180
`define SEW_PROT2_BASE     9'h100
`define SEW_PAGE_BYTES     4
`define SEW_PROG_CYCLES    32'd1000

`endif

// *** include/sew_pkg.sv ***
// types of the serial eeprom write-control block
package sew_pkg;

    typedef enum logic [2:0] {
        SPI_IDLE,
        SPI_OPCODE,
        SPI_ADDR,
        SPI_DATA,
        SPI_STORE,
        SPI_STORE_DONE,
        SPI_LATCH,
        SPI_OUT
    } sew_spi_t;

    typedef enum logic [1:0] {
        PG_IDLE,
        PG_LOAD,
        PG_WAIT
    } sew_pg_t;

endpackage

// *** core/sew_fifo.sv ***
// small synchronous fifo between page buffer and array write port
`timescale 1ns/100ps
module sew_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= ptr_next(wr_q);
            end
            if (pop) begin
                rd_q <= ptr_next(rd_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// *** core/sew_write_ctrl.sv ***
// write-control logic of a 512 x 8 serial eeprom behind a four-wire link
`timescale 1ns/100ps
`include "sew_defines.svh"
module sew_write_ctrl #(
    parameter int PROG_CYCLES = `SEW_PROG_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe_n,
    output logic            prog_valid,
    input  wire logic       prog_ready,
    output logic [8:0]      prog_addr,
    output logic [7:0]      prog_data,
    output logic            busy,
    output logic [7:0]      state_byte
);
    // ----------------------------------------------------------------
    // pin synchronisers and edge finders
    // ----------------------------------------------------------------
    logic [2:0] cs_q;
    logic [2:0] sck_q;
    logic [1:0] si_q;
    logic [1:0] wp_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cs_q  <= 3'h7;
            sck_q <= 3'h0;
            si_q  <= 2'h0;
            wp_q  <= 2'h0;
        end else begin
            cs_q  <= {cs_q[1:0], cs_n};
            sck_q <= {sck_q[1:0], sck};
            si_q  <= {si_q[0], si};
            wp_q  <= {wp_q[0], wp_n};
        end
    end

    logic sel;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic wp_high;

    assign sel      = !cs_q[1];
    assign cs_rise  = cs_q[1] && !cs_q[2];
    assign sck_rise = sel && sck_q[1] && !sck_q[2];
    assign sck_fall = sel && !sck_q[1] && sck_q[2];
    assign wp_high  = wp_q[1];

    // ----------------------------------------------------------------
    // serial receive
    // ----------------------------------------------------------------
    sew_pkg::sew_spi_t spi_q;
    sew_pkg::sew_pg_t  pg_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] bit_q;
    logic       byte_done;
    logic       latch_q;
    logic [1:0] prot_q;
    logic       latch_set_q;
    assign shift_d   = {shift_q[6:0], si_q[1]};
    assign byte_done = sck_rise && (bit_q == 3'h7);
    assign busy      = (pg_q != sew_pkg::PG_IDLE);
    always_ff @(posedge mclk) begin
        if (!rst_n || !sel) begin
            bit_q <= 3'h0;
        end else if (sck_rise) begin
            bit_q <= bit_q + 1'b1;
        end
    end

    // unknown opcode and output phase freeze the shifter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
        end else if (sck_rise && spi_q inside {sew_pkg::SPI_OPCODE, sew_pkg::SPI_ADDR,
                                            sew_pkg::SPI_DATA, sew_pkg::SPI_STORE}) begin
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !sel) begin
            spi_q <= sew_pkg::SPI_IDLE;
        end else begin
            case (spi_q)
                sew_pkg::SPI_IDLE: begin
                    spi_q <= sew_pkg::SPI_OPCODE;
                end
                sew_pkg::SPI_OPCODE: begin
                    if (byte_done) begin
                        if (shift_d == `SEW_OP_READ_STATE) begin
                            spi_q <= sew_pkg::SPI_OUT;
                        end else if (busy) begin
                            spi_q <= sew_pkg::SPI_LATCH;
                        end else if ((shift_d & `SEW_OP_RW_MASK) == `SEW_OP_WRITE) begin
                            spi_q <= sew_pkg::SPI_ADDR;
                        end else if (shift_d == `SEW_OP_STORE_PROT) begin
                            spi_q <= sew_pkg::SPI_STORE;
                        end else begin
                            // latch commands wait here; anything else is dropped
                            spi_q <= sew_pkg::SPI_LATCH;
                        end
                    end
                end
                sew_pkg::SPI_ADDR: begin
                    if (byte_done) begin
                        spi_q <= sew_pkg::SPI_DATA;
                    end
                end
                sew_pkg::SPI_STORE: begin
                    if (byte_done) begin
                        spi_q <= sew_pkg::SPI_STORE_DONE;
                    end
                end
                default: begin
                    spi_q <= spi_q;
                end
            endcase
        end
    end

    // only a latch opcode seen while idle may act at chip select rise
    always_ff @(posedge mclk) begin
        if (!rst_n || !sel) begin
            latch_set_q <= 1'b0;
        end else if (spi_q == sew_pkg::SPI_OPCODE && byte_done) begin
            latch_set_q <= !busy && (shift_d == `SEW_OP_SET_LATCH ||
                                     shift_d == `SEW_OP_CLR_LATCH);
        end
    end

    // ----------------------------------------------------------------
    // address and page buffer
    // ----------------------------------------------------------------
    logic [6:0] hi_q;
    logic [1:0] lo_q;
    logic [7:0] page_q [`SEW_PAGE_BYTES];
    logic [3:0] pvld_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hi_q <= 7'h00;
            lo_q <= 2'h0;
        end else if (byte_done && spi_q == sew_pkg::SPI_OPCODE) begin
            hi_q[6] <= shift_d[`SEW_OP_A8_POS];
        end else if (byte_done && spi_q == sew_pkg::SPI_ADDR) begin
            hi_q[5:0] <= shift_d[7:2];
            lo_q      <= shift_d[1:0];
        end else if (byte_done && spi_q == sew_pkg::SPI_DATA) begin
            lo_q <= lo_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || spi_q == sew_pkg::SPI_IDLE && sel) begin
            pvld_q <= 4'h0;
        end else if (byte_done && spi_q == sew_pkg::SPI_DATA) begin
            page_q[lo_q] <= shift_d;
            pvld_q[lo_q] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // commit decisions at chip select rise
    // ----------------------------------------------------------------
    logic aligned;
    logic go_write;
    logic go_store;
    logic prog_done;

    // rise mid-byte means the master broke the framing; drop the command
    assign aligned  = cs_rise && (bit_q == 3'h0) && !busy;
    assign go_write = aligned && spi_q == sew_pkg::SPI_DATA && pvld_q != 4'h0
                      && latch_q && wp_high;
    assign go_store = aligned && spi_q == sew_pkg::SPI_STORE_DONE
                      && latch_q && wp_high;
    // shifter is frozen on the opcode once a latch command is recognised
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
        end else if (prog_done) begin
            latch_q <= 1'b0;
        end else if (aligned && latch_set_q) begin
            latch_q <= (shift_q == `SEW_OP_SET_LATCH);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prot_q <= `SEW_PROT_RESET;
        end else if (go_store) begin
            prot_q <= shift_q[`SEW_ST_PROT_HI:`SEW_ST_PROT_LO];
        end
    end

    // ----------------------------------------------------------------
    // self-timed programming
    // ----------------------------------------------------------------
    function automatic logic is_protected(input logic [1:0] lvl, input logic [8:0] a);
        case (lvl)
            2'h1:    is_protected = (a >= `SEW_PROT1_BASE);
            2'h2:    is_protected = (a >= `SEW_PROT2_BASE);
            2'h3:    is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction
    logic [1:0]  idx_q;
    logic [31:0] timer_q;
    logic [8:0]  cur_addr;
    logic        push_valid;
    logic        push_ready;
    assign cur_addr   = {hi_q, idx_q};
    assign push_valid = (pg_q == sew_pkg::PG_LOAD) && pvld_q[idx_q]
                        && !is_protected(prot_q, cur_addr);
    assign prog_done  = (pg_q == sew_pkg::PG_WAIT) && (timer_q == 32'h0) && !prog_valid;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pg_q <= sew_pkg::PG_IDLE;
        end else begin
            case (pg_q)
                sew_pkg::PG_IDLE: begin
                    if (go_write) begin
                        pg_q <= sew_pkg::PG_LOAD;
                    end else if (go_store) begin
                        pg_q <= sew_pkg::PG_WAIT;
                    end
                end
                sew_pkg::PG_LOAD: begin
                    if ((!push_valid || push_ready) && idx_q == 2'h3) begin
                        pg_q <= sew_pkg::PG_WAIT;
                    end
                end
                sew_pkg::PG_WAIT: begin
                    if (prog_done) begin
                        pg_q <= sew_pkg::PG_IDLE;
                    end
                end
                default: begin
                    pg_q <= sew_pkg::PG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || pg_q == sew_pkg::PG_IDLE) begin
            idx_q <= 2'h0;
        end else if (pg_q == sew_pkg::PG_LOAD && (!push_valid || push_ready)) begin
            idx_q <= idx_q + 1'b1;
        end
    end

    // timer starts when the cycle is committed; the fifo drain overlaps it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_q <= 32'h0;
        end else if (go_write || go_store) begin
            timer_q <= 32'(PROG_CYCLES - 1);
        end else if (timer_q != 32'h0) begin
            timer_q <= timer_q - 1'b1;
        end
    end

    sew_fifo #(
        .WIDTH (17),
        .DEPTH (`SEW_PAGE_BYTES)
    ) i_sew_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({cur_addr, page_q[idx_q]}),
        .out_valid (prog_valid),
        .out_ready (prog_ready),
        .out_data  ({prog_addr, prog_data})
    );

    // ----------------------------------------------------------------
    // state byte and serial output
    // ----------------------------------------------------------------
    assign state_byte = {4'h0, prot_q, latch_q, busy};

    logic [7:0] out_sr_q;
    logic [2:0] out_cnt_q;
    logic       drive_q;

    // driver stays off until the first falling edge of the output phase
    always_ff @(posedge mclk) begin
        if (!rst_n || spi_q != sew_pkg::SPI_OUT) begin
            out_sr_q  <= state_byte;
            out_cnt_q <= 3'h0;
            so        <= 1'b0;
            drive_q   <= 1'b0;
        end else if (sck_fall) begin
            so        <= out_sr_q[7];
            drive_q   <= 1'b1;
            out_cnt_q <= out_cnt_q + 1'b1;
            // reload each byte so repeated polling sees live busy
            out_sr_q  <= (out_cnt_q == 3'h7) ? state_byte : {out_sr_q[6:0], 1'b0};
        end
    end
    assign so_oe_n = !drive_q;
endmodule

// *** testbench/sew_write_ctrl_assertions.sv ***
// concurrent checks on the ports of the write-control block
`timescale 1ns/100ps
module sew_write_ctrl_assertions #(
    parameter int PROG_CYCLES = 1000
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe_n,
    input wire logic       prog_valid,
    input wire logic       prog_ready,
    input wire logic [8:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic       busy,
    input wire logic [7:0] state_byte
);
    logic [15:0] busy_cnt_q;
    logic [1:0]  lvl;
    assign lvl = state_byte[3:2];

    // ----------------------------------------------------------------
    // busy length counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || !busy)
            busy_cnt_q <= 16'h0000;
        else
            busy_cnt_q <= busy_cnt_q + 16'h0001;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_reset_clear;
        $rose(rst_n) |-> state_byte == 8'h00 && so_oe_n && !prog_valid;
    endproperty
    property p_busy_bit;
        state_byte[0] == busy && state_byte[7:4] == 4'h0;
    endproperty
    property p_busy_min;
        $fell(busy) |-> busy_cnt_q >= PROG_CYCLES - 2;
    endproperty
    property p_busy_max;
        busy |-> busy_cnt_q < PROG_CYCLES + 3000;
    endproperty
    property p_latch_set;
        $rose(state_byte[1]) |-> cs_n && !busy;
    endproperty
    property p_latch_auto_clear;
        $fell(busy) |-> !state_byte[1];
    endproperty
    property p_commit_needs_latch;
        $rose(busy) |-> state_byte[1] && wp_n;
    endproperty
    property p_no_protected;
        prog_valid |-> !(lvl == 2'h3 || (lvl == 2'h2 && prog_addr >= 9'h100)
                         || (lvl == 2'h1 && prog_addr >= 9'h180));
    endproperty
    property p_oe_idle;
        cs_n [*6] |-> so_oe_n;
    endproperty
    property p_busy_frozen;
        busy && $past(busy) |-> $stable(state_byte[3:1]);
    endproperty
    property p_hold;
        prog_valid && !prog_ready |=> prog_valid && $stable(prog_addr) && $stable(prog_data);
    endproperty

    a_reset_clear: assert property (p_reset_clear)
        else $error("state not cleared by reset");
    a_busy_bit: assert property (p_busy_bit)
        else $error("state byte does not follow busy");
    a_busy_min: assert property (p_busy_min)
        else $error("busy period too short");
    a_busy_max: assert property (p_busy_max)
        else $error("busy period never ends");
    a_latch_set: assert property (p_latch_set)
        else $error("latch set while selected or busy");
    a_latch_auto_clear: assert property (p_latch_auto_clear)
        else $error("latch left set after cycle");
    a_commit_needs_latch: assert property (p_commit_needs_latch)
        else $error("cycle started without latch");
    a_no_protected: assert property (p_no_protected)
        else $error("protected byte presented");
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while deselected");
    a_busy_frozen: assert property (p_busy_frozen)
        else $error("latch or protection changed while busy");
    a_hold: assert property (p_hold)
        else $error("array request changed before taken");

    c_busy: cover property ($rose(busy));
    c_beat: cover property (prog_valid && prog_ready);
    c_read: cover property ($fell(so_oe_n));
endmodule

bind sew_write_ctrl sew_write_ctrl_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_sew_chk (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .state_byte(state_byte)
);

// *** testbench/sew_spi_host.sv ***
// link master model that frames commands towards the eeprom
`timescale 1ns/100ps
module sew_spi_host (
    input  wire logic mclk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    localparam int HALF = 10;
    logic [7:0] rx;
    logic       oe_seen;

    // mode 0: clock rests low outside frames
    initial begin
        cs_n    = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
        oe_seen = 1'b0;
    end

    task automatic half();
        repeat (HALF) @(negedge mclk);
    endtask

    task automatic open_frame();
        cs_n = 1'b0;
        half();
    endtask

    task automatic xbyte(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            half();
            // released line floats to the master's pull-up level
            rx[i] = (so_oe_n === 1'b0) ? so : 1'b1;
            if (so_oe_n === 1'b0)
                oe_seen = 1'b1;
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask

    // rise inside the clock-low time after the last bit
    task automatic close_frame();
        half();
        cs_n = 1'b1;
        si   = ~si;
        half();
        half();
    endtask
endmodule

// *** testbench/tb_sew_write_ctrl.sv ***
// self-checking bench of the eeprom write-control block
`timescale 1ns/100ps
`include "sew_defines.svh"
module tb_sew_write_ctrl;
    localparam int PROG = 20;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wp_n = 1'b1;
    logic        prog_ready = 1'b1;
    logic        stall = 1'b0;
    logic        cs_n, sck, si, so, so_oe_n, prog_valid, busy;
    logic [8:0]  prog_addr;
    logic [7:0]  prog_data, state_byte, v;
    logic [16:0] exp_q[$];
    logic [7:0]  pg[4];
    logic [3:0]  pv;
    logic [8:0]  adr[3] = '{9'h0FC, 9'h17C, 9'h1FC};
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed = 59407;

    always #2 mclk = ~mclk;

    sew_write_ctrl #(.PROG_CYCLES(PROG)) i_sew_write_ctrl (
        .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe_n(so_oe_n), .prog_valid(prog_valid), .prog_ready(prog_ready),
        .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .state_byte(state_byte)
    );
    sew_spi_host i_sew_spi_host (
        .mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n)
    );

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic hit(input logic [1:0] l, input logic [8:0] a);
        return l == 2'h3 || (l == 2'h2 && a >= 9'h100) || (l == 2'h1 && a >= 9'h180);
    endfunction

    // ----------------------------------------------------------------
    // link frames
    // ----------------------------------------------------------------
    task automatic frame(input logic [7:0] op, input logic [7:0] b, input logic two);
        i_sew_spi_host.open_frame();
        i_sew_spi_host.xbyte(op);
        if (two)
            i_sew_spi_host.xbyte(b);
        i_sew_spi_host.close_frame();
    endtask

    task automatic rd_state(output logic [7:0] r);
        i_sew_spi_host.open_frame();
        i_sew_spi_host.xbyte(`SEW_OP_READ_STATE);
        i_sew_spi_host.xbyte(8'($random(seed)));
        r = i_sew_spi_host.rx;
        i_sew_spi_host.close_frame();
    endtask

    // expected beats are noted in slot order before the frame closes
    task automatic page(input logic [8:0] a, input int n, input logic ok);
        logic [7:0] d;
        pv = 4'h0;
        i_sew_spi_host.open_frame();
        i_sew_spi_host.xbyte(`SEW_OP_WRITE | {4'h0, a[8], 3'h0});
        i_sew_spi_host.xbyte(a[7:0]);
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            i_sew_spi_host.xbyte(d);
            pg[2'(a[1:0] + 2'(k))] = d;
            pv[2'(a[1:0] + 2'(k))] = 1'b1;
        end
        for (int s = 0; s < 4; s++)
            if (ok && pv[s])
                exp_q.push_back({a[8:2], 2'(s), pg[s]});
        i_sew_spi_host.close_frame();
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 20; k++) begin
            rd_state(v);
            if (v[0] === 1'b0)
                return;
        end
        failures++;
    endtask

    // ----------------------------------------------------------------
    // array side: stalls and beat comparison
    // ----------------------------------------------------------------
    always @(negedge mclk)
        prog_ready <= !stall && (($random(seed) & 1) == 1);

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            finish_test();
        end
        if (rst_n && prog_valid === 1'b1 && prog_ready) begin
            if (exp_q.size() == 0)
                check({prog_addr, prog_data}, ~{prog_addr, prog_data});
            else
                check({prog_addr, prog_data}, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        rd_state(v);
        check(v, 8'h00);
        page(9'h010, 1, 1'b0);
        rd_state(v);
        check(v, 8'h00);
        frame(`SEW_OP_SET_LATCH, 8'h00, 1'b0);
        rd_state(v);
        check(v, 8'h02);
        frame(`SEW_OP_CLR_LATCH, 8'h00, 1'b0);
        rd_state(v);
        check(v, 8'h00);
        frame(`SEW_OP_SET_LATCH, 8'h00, 1'b0);
        wp_n = 1'b0;
        page(9'h020, 2, 1'b0);
        frame(`SEW_OP_STORE_PROT, 8'h0C, 1'b1);
        wp_n = 1'b1;
        rd_state(v);
        check(v, 8'h02);
        stall = 1'b1;
        page(9'h10A, 6, 1'b1);
        rd_state(v);
        check(v[0], 1'b1);
        frame(`SEW_OP_STORE_PROT, 8'h0C, 1'b1);
        stall = 1'b0;
        wait_idle();
        rd_state(v);
        check(v, 8'h00);
        for (int l = 0; l < 4; l++) begin
            frame(`SEW_OP_SET_LATCH, 8'h00, 1'b0);
            frame(`SEW_OP_STORE_PROT, (8'($random(seed)) & 8'hF3) | 8'(l << 2), 1'b1);
            wait_idle();
            rd_state(v);
            check(v, 8'(l << 2));
            for (int j = 0; j < 3; j++) begin
                frame(`SEW_OP_SET_LATCH, 8'h00, 1'b0);
                page(adr[j], 1, !hit(2'(l), adr[j]));
                wait_idle();
            end
        end
        i_sew_spi_host.oe_seen = 1'b0;
        frame(8'hFF, 8'h55, 1'b1);
        frame(`SEW_OP_READ, 8'h00, 1'b1);
        check(i_sew_spi_host.oe_seen, 1'b0);
        rd_state(v);
        check(v, 8'h0C);
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule
